// *** rtl/pcc_top.sv ***
// pll core clock control register, lock flag and core clock select
`timescale 1ns/1ps
`include "pcc_consts.svh"
module pcc_top
    import pcc_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic [1:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic      [31:0] avs_readdata_out,
    output logic             avs_waitrequest_out,
    input  wire logic        pll_lock_in,
    input  wire logic        external_access_pin_in,
    input  wire logic        power_down_in,
    input  wire logic        irq_service_in,
    output logic             osc_enable_out,
    output logic      [8:0]  pll_mult_out,
    output logic             core_clk_en_out
);
    pcc_div_if      div_link ();
    pcc_bus_state_t bus_state;
    pcc_bus_state_t next_bus_state;
    logic [7:0]     ctrl;
    logic [7:0]     next_ctrl;
    logic [31:0]    next_readdata;
    logic           lock_s1;
    logic           lock_s2;
    logic           ext_s1;
    logic           ext_s2;
    logic [1:0]     ext_wait;
    logic [1:0]     next_ext_wait;
    logic           ext_access_pin_latched;
    logic           next_ext_latched;
    logic           next_osc_enable;
    logic           req;
    logic           take;
    logic [7:0]     status;

    ////////////////////////////////////////////////////////////////////
    // bus slave: one wait state, then the answer
    assign req  = avs_read_in | avs_write_in;
    assign take = req && (bus_state == PCC_BUS_DONE);
    assign avs_waitrequest_out = req && (bus_state == PCC_BUS_IDLE);

    // read view of the control register
    always_comb
    begin
        status = ctrl;
        status[`PCC_BIT_LOCKED]    = lock_s2;
        status[`PCC_BIT_RSVD]      = 1'b0;
        status[`PCC_BIT_EXT_LATCH] = ext_access_pin_latched;
    end

    // bus handshake, register update and read data
    always_comb
    begin
        next_bus_state = PCC_BUS_IDLE;
        if (req && bus_state == PCC_BUS_IDLE)
        begin
            next_bus_state = PCC_BUS_DONE;
        end
        next_ctrl = ctrl;
        if (take && avs_write_in && avs_byteenable_in[0]
            && avs_address_in == `PCC_CTRL_WORD)
        begin
            next_ctrl = avs_writedata_in[7:0] & `PCC_CTRL_WMASK;
        end
        next_readdata = avs_readdata_out;
        if (avs_read_in && bus_state == PCC_BUS_IDLE)
        begin
            next_readdata = `PCC_READ_ZERO;
            if (avs_address_in == `PCC_CTRL_WORD)
            begin
                next_readdata[7:0] = status;
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            bus_state        <= PCC_BUS_IDLE;
            ctrl             <= `PCC_CTRL_RESET;
            avs_readdata_out <= `PCC_READ_ZERO;
        end
        else
        begin
            bus_state        <= next_bus_state;
            ctrl             <= next_ctrl;
            avs_readdata_out <= next_readdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            lock_s1 <= 1'b0;
            lock_s2 <= 1'b0;
            ext_s1  <= 1'b0;
            ext_s2  <= 1'b0;
        end
        else
        begin
            lock_s1 <= pll_lock_in;
            lock_s2 <= lock_s1;
            ext_s1  <= external_access_pin_in;
            ext_s2  <= ext_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // external-access capture once the synchroniser has settled
    // only the second flop is read; the last load holds the pin level
    // as sampled at the first edge after reset release
    always_comb
    begin
        next_ext_wait    = ext_wait;
        next_ext_latched = ext_access_pin_latched;
        if (ext_wait != `PCC_EXT_SETTLE)
        begin
            next_ext_wait = 2'(ext_wait + 2'h1);
            next_ext_latched = ext_s2;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ext_wait               <= 2'h0;
            ext_access_pin_latched <= 1'b0;
        end
        else
        begin
            ext_wait               <= next_ext_wait;
            ext_access_pin_latched <= next_ext_latched;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // oscillator control and pll multiplier setting
    assign next_osc_enable =
        !(power_down_in && ctrl[`PCC_BIT_OSC_HALT]);

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            osc_enable_out <= 1'b1;
            pll_mult_out   <= `PCC_PLL_MULT;
        end
        else
        begin
            osc_enable_out <= next_osc_enable;
            pll_mult_out   <= `PCC_PLL_MULT;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // divider code, forced to full rate while servicing an interrupt
    assign div_link.code =
        (ctrl[`PCC_BIT_FAST_IRQ] && irq_service_in) ? `PCC_DIV_FASTEST
        : ctrl[`PCC_DIV_MSB:`PCC_DIV_LSB];
    assign core_clk_en_out = div_link.tick;

    pcc_clkdiv u_div
    (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .link   (div_link)
    );

    ////////////////////////////////////////////////////////////////////
    // checks on oscillator, lock flag, pin capture, divider and bus
    osc_halt_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (power_down_in && ctrl[`PCC_BIT_OSC_HALT]) |=> !osc_enable_out)
        else $error("oscillator not halted in power-down");

    osc_run_a: assert property (@(posedge clk_in) disable iff (rst_in)
        !ctrl[`PCC_BIT_OSC_HALT] |=> osc_enable_out)
        else $error("oscillator stopped with halt bit clear");

    lock_flag_a: assert property (@(posedge clk_in) disable iff (rst_in)
        pll_lock_in [*3] |-> status[`PCC_BIT_LOCKED])
        else $error("lock flag does not follow the pll");

    ext_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (ext_wait == `PCC_EXT_SETTLE) |=> $stable(ext_access_pin_latched))
        else $error("latched pin level changed after capture");

    fast_irq_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (ctrl[`PCC_BIT_FAST_IRQ] && irq_service_in)
        |-> div_link.code == `PCC_DIV_FASTEST)
        else $error("interrupt not serviced at full clock");

    reset_val_a: assert property (@(posedge clk_in)
        $fell(rst_in) |-> ctrl == `PCC_CTRL_RESET)
        else $error("control register reset value wrong");

    wait_state_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (req && bus_state == PCC_BUS_IDLE) |-> avs_waitrequest_out
        ##1 (!req || !avs_waitrequest_out))
        else $error("bus answer timing wrong");

    write_take_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (take && avs_write_in && avs_byteenable_in[0]
         && avs_address_in == `PCC_CTRL_WORD)
        |=> ctrl == ($past(avs_writedata_in[7:0]) & `PCC_CTRL_WMASK))
        else $error("control write not stored");

    mult_a: assert property (@(posedge clk_in) disable iff (rst_in)
        pll_mult_out == `PCC_PLL_MULT)
        else $error("pll multiplier setting wrong");
endmodule : pcc_top

// *** rtl/pcc_consts.svh ***
// constants of the pll core clock control block
`ifndef PCC_CONSTS_SVH
`define PCC_CONSTS_SVH
`define PCC_CTRL_WORD      2'h0
`define PCC_CTRL_RESET     8'h03
`define PCC_CTRL_WMASK     8'hDF
`define PCC_BIT_OSC_HALT   7
`define PCC_BIT_LOCKED     6
`define PCC_BIT_RSVD       5
`define PCC_BIT_EXT_LATCH  4
`define PCC_BIT_FAST_IRQ   3
`define PCC_DIV_MSB        2
`define PCC_DIV_LSB        0
`define PCC_DIV_FASTEST    3'h0
`define PCC_PLL_MULT       9'h180
`define PCC_EXT_SETTLE     2'h3
`define PCC_READ_ZERO      32'h0000_0000
`endif

// *** rtl/pcc_pkg.sv ***
// types shared by the pll core clock control modules
package pcc_pkg;
    typedef logic [2:0] pcc_div_code_t;
    typedef enum logic [0:0]
    {
        PCC_BUS_IDLE = 1'b0,
        PCC_BUS_DONE = 1'b1
    } pcc_bus_state_t;
endpackage : pcc_pkg

// *** rtl/pcc_div_if.sv ***
// link between the control register and the core clock divider
`timescale 1ns/1ps
interface pcc_div_if;
    import pcc_pkg::*;
    pcc_div_code_t code;
    logic          tick;
    modport ctrl (output code, input tick);
    modport div  (input code, output tick);
endinterface : pcc_div_if

// *** rtl/pcc_clkdiv.sv ***
// core clock divider, changes ratio only at a period boundary
`timescale 1ns/1ps
`include "pcc_consts.svh"
module pcc_clkdiv
    import pcc_pkg::*;
(
    input  wire logic clk_in,
    input  wire logic rst_in,
    pcc_div_if.div    link
);
    logic [6:0]    count;
    logic [6:0]    next_count;
    pcc_div_code_t cur_code;
    pcc_div_code_t next_cur_code;
    logic [6:0]    last;

    ////////////////////////////////////////////////////////////////////
    // terminal count is two to the code, minus one
    function automatic logic [6:0] pcc_last_count(input pcc_div_code_t c);
        pcc_last_count = 7'((8'h01 << c) - 8'h01);
    endfunction : pcc_last_count

    assign last      = pcc_last_count(cur_code);
    assign link.tick = (count == last);

    // new code only after a whole period, so no short pulse
    always_comb
    begin
        next_count    = link.tick ? 7'h00 : 7'(count + 7'h01);
        next_cur_code = link.tick ? link.code : cur_code;
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            count    <= 7'h00;
            cur_code <= 3'(`PCC_CTRL_RESET);
        end
        else
        begin
            count    <= next_count;
            cur_code <= next_cur_code;
        end
    end

    ////////////////////////////////////////////////////////////////////
    stable_ratio_a: assert property (@(posedge clk_in) disable iff (rst_in)
        !link.tick |=> $stable(cur_code))
        else $error("divider ratio changed inside a period");

    div_eight_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (link.tick && link.code == 3'h3 && cur_code == 3'h3)
        |=> !link.tick [*7] ##1 link.tick)
        else $error("divide by eight period wrong");

    div_one_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (cur_code == `PCC_DIV_FASTEST) |-> link.tick)
        else $error("full rate must tick every cycle");
endmodule : pcc_clkdiv

// *** verif/pcc_core_model.sv ***
// model of the crystal, pll lock detect and the core's sleep and irq levels
`timescale 1ns/1ps
module pcc_core_model
#(
    parameter int LOCK_CYCLES = 20
)
(
    input  wire logic clk_in,
    input  wire logic osc_enable_in,
    input  wire logic sleep_req_in,
    input  wire logic irq_req_in,
    output logic      pll_lock_out,
    output logic      power_down_out,
    output logic      irq_service_out
);
    int lock_count = 0;
    //////////////////////////////////////////////////
    // lock comes only after the crystal has run a while
    always @(posedge clk_in)
    begin
        if (!osc_enable_in)
            lock_count <= 0;
        else if (lock_count < LOCK_CYCLES)
            lock_count <= lock_count + 1;
        power_down_out  <= sleep_req_in;
        irq_service_out <= irq_req_in;
    end
    assign pll_lock_out = (lock_count >= LOCK_CYCLES);
endmodule : pcc_core_model

// *** verif/tb_top.sv ***
// self-checking bench of the pll core clock control block
`timescale 1ns/1ps
module tb_top;
    logic        clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic [1:0]  avs_address_in = 2'h0;
    logic        avs_read_in = 1'b0;
    logic        avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0000_0000;
    logic [3:0]  avs_byteenable_in = 4'h1;
    logic        external_access_pin_in = 1'b1;
    logic        sleep_req = 1'b0;
    logic        irq_req = 1'b0;
    logic [31:0] avs_readdata_out, q;
    logic        avs_waitrequest_out, pll_lock_in, power_down_in;
    logic        irq_service_in, osc_enable_out, core_clk_en_out;
    logic [8:0]  pll_mult_out;
    logic [31:0] seed = 32'h0000_c852;
    logic [7:0]  shadow = 8'h03;
    int          fail_count = 0, checked = 0, cyc = 0, last = 0, gap = 0;
    int          prev = 3;
    int          codes[8] = '{0, 7, 1, 6, 2, 5, 4, 3};

    pcc_top dut (.clk_in, .rst_in, .avs_address_in, .avs_read_in,
        .avs_write_in, .avs_writedata_in, .avs_byteenable_in,
        .avs_readdata_out, .avs_waitrequest_out, .pll_lock_in,
        .external_access_pin_in, .power_down_in, .irq_service_in,
        .osc_enable_out, .pll_mult_out, .core_clk_en_out);
    pcc_core_model core (.clk_in, .osc_enable_in(osc_enable_out),
        .sleep_req_in(sleep_req), .irq_req_in(irq_req),
        .pll_lock_out(pll_lock_in), .power_down_out(power_down_in),
        .irq_service_out(irq_service_in));
    //////////////////////////////////////////////////
    // clock and the spacing of core ticks
    initial
        forever #5 clk_in = ~clk_in;
    always @(posedge clk_in)
    begin
        cyc <= cyc + 1;
        if (core_clk_en_out === 1'b1)
        begin
            gap  <= cyc - last;
            last <= cyc;
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // control word as read while locked
    function automatic logic [31:0] exp_ctrl(input logic [7:0] w,
                                              input logic ea);
        return {24'h00_0000, w[7], 1'b1, 1'b0, ea, w[3:0]};
    endfunction : exp_ctrl
    task chk(input string name, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, e, g);
        end
    endtask : chk
    // one avalon transfer, held until waitrequest is sampled low
    task bus(input logic wr, input logic [1:0] a, input logic [7:0] d,
             input logic [3:0] be);
        int n;
        n = 0;
        @(posedge clk_in);
        avs_read_in       <= !wr;
        avs_write_in      <= wr;
        avs_address_in    <= a;
        avs_writedata_in  <= {seed[31:8], d};
        avs_byteenable_in <= be;
        do
        begin
            @(posedge clk_in);
            n++;
        end
        while (avs_waitrequest_out !== 1'b0 && n < 50);
        q = avs_readdata_out;
        avs_read_in  <= 1'b0;
        avs_write_in <= 1'b0;
        if (n >= 50)
            fail_count++;
    endtask : bus
    task wait_tick;
        int n;
        n = 0;
        do
        begin
            @(negedge clk_in);
            n++;
        end
        while (core_clk_en_out !== 1'b1 && n < 300);
        @(negedge clk_in);
        if (n >= 300)
            fail_count++;
    endtask : wait_tick
    task gap_is(input int e);
        repeat (3) wait_tick;
        chk("tick gap", 32'(e), 32'(gap));
    endtask : gap_is
    task set_irq(input logic v);
        @(posedge clk_in);
        irq_req <= v;
    endtask : set_irq
    task poll_lock;
        int n;
        n = 0;
        do
        begin
            bus(1'b0, 2'h0, 8'h00, 4'h1);
            n++;
        end
        while (q[6] !== 1'b1 && n < 40);
    endtask : poll_lock
    task finish_test;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    //////////////////////////////////////////////////
    // watchdog
    initial
    begin
        repeat (20000) @(posedge clk_in);
        fail_count++;
        finish_test;
    end
    // main sequence
    initial
    begin
        repeat (12) @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        external_access_pin_in <= 1'b0;
        poll_lock;
        chk("ctrl reset", exp_ctrl(8'h03, 1'b1), q);
        chk("pll mult", 32'h0000_0180, {23'h0, pll_mult_out});
        $display("test reset done");
        foreach (codes[i])
        begin
            bus(1'b1, 2'h0, {5'h00, 3'(codes[i])}, 4'h1);
            wait_tick;
            chk("gap at switch", 32'(1 << prev), 32'(gap));
            gap_is(1 << codes[i]);
            prev = codes[i];
        end
        $display("test divider done");
        bus(1'b1, 2'h0, 8'h0b, 4'h1);
        gap_is(8);
        set_irq(1'b1);
        gap_is(1);
        set_irq(1'b0);
        gap_is(8);
        set_irq(1'b1);
        bus(1'b1, 2'h0, 8'h03, 4'h1);
        gap_is(8);
        set_irq(1'b0);
        $display("test fast irq done");
        repeat (16)
        begin
            seed = lfsr(seed);
            external_access_pin_in <= seed[13];
            bus(1'b1, seed[9:8], seed[7:0] & 8'hdf, {3'h0, seed[10]});
            if (seed[9:8] == 2'h0 && seed[10])
                shadow = seed[7:0] & 8'hdf;
            bus(1'b0, seed[12:11], 8'h00, 4'h1);
            chk("random read", (seed[12:11] == 2'h0) ?
                exp_ctrl(shadow, 1'b1) : 32'h0000_0000, q);
        end
        bus(1'b1, 2'h0, 8'h03, 4'h1);
        $display("test random done");
        bus(1'b1, 2'h0, 8'h83, 4'h1);
        sleep_req <= 1'b1;
        repeat (8) @(negedge clk_in);
        chk("osc halted", 32'h0, {31'h0, osc_enable_out});
        bus(1'b0, 2'h0, 8'h00, 4'h1);
        chk("lock lost", 32'h0000_0093, q);
        sleep_req <= 1'b0;
        poll_lock;
        chk("lock back", 32'h0000_00d3, q);
        bus(1'b1, 2'h0, 8'h03, 4'h1);
        sleep_req <= 1'b1;
        repeat (4) @(negedge clk_in);
        chk("osc kept", 32'h1, {31'h0, osc_enable_out});
        @(posedge clk_in);
        sleep_req <= 1'b0;
        $display("test power down done");
        @(posedge clk_in);
        rst_in <= 1'b1;
        external_access_pin_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        external_access_pin_in <= 1'b1;
        poll_lock;
        chk("ctrl second reset", 32'h0000_0043, q);
        $display("test second reset done");
        finish_test;
    end
endmodule : tb_top
